// ===== common/pump_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PUMP_MAP_SVH
`define PUMP_MAP_SVH
`define CLK_HZ        25000000
`define BAUD_300      300
`define BAUD_1200     1200
`define BAUD_2400     2400
`define BAUD_9600     9600
`define BAUD_19200    19200
`define BIT_CYC(b)    (`CLK_HZ / (b))
`define GAP_MS        500
`define GAP_CYC       (`CLK_HZ / 1000 * `GAP_MS)
`define OFS_CTRL      8'h00
`define OFS_STAT      8'h04
`define OFS_RESP      8'h08
`define OFS_CMD0      8'h10
`define OFS_CMD3      8'h1C
`define CTRL_BAUD_LSB 0
`define CTRL_ADDR_LSB 8
`define CTRL_CHK_BIT  16
`define CTRL_EDIT_BIT 17
`define CTRL_MENU_BIT 18
`define RST_BAUD      3'h4
`define RST_ADDR      7'h00
`define ADDR_MAX      7'h63
`define CH_STX        8'h02
`define CH_ETX        8'h03
`define CH_SPACE      8'h20
`define CH_DEL        8'h7F
`define CH_ZERO       8'h30
`define CRC_POLY      16'h1021
`define CRC_INIT      16'h0000
`define PKT_OVH       8'h04
`define RESP_LEN      8'h07
`define BUF_DEPTH     16
`endif

// ===== common/pump_pkg.sv
// Types shared by the pump serial front end
package pump_pkg;
	// Receive packet parser states
	typedef enum logic [2:0] {P_IDLE, P_LEN, P_DATA, P_CRC1, P_CRC2, P_ETX} parse_e;
	// Response sender states
	typedef enum logic [3:0] {T_IDLE, T_STX, T_LEN, T_A1, T_A0, T_ST, T_C1, T_C0,
		T_ETX} resp_e;
endpackage : pump_pkg

// ===== core/serial_rx.sv
// Serial receiver, one start, eight data, one stop bit
`timescale 1ns/1ps
module serial_rx (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        rxd,     // Line, idle high
	input  wire logic [16:0] bit_cyc, // Clocks per bit
	output logic      [7:0]  data_r,  // Received byte
	output logic             vld_r    // One-cycle strobe
);
	logic        act_r, act_nxt;   // Inside a frame
	logic [16:0] cnt_r, cnt_nxt;   // Bit timer
	logic [3:0]  bit_r, bit_nxt;   // Bit index, 0 is start
	logic [7:0]  sh_r,  sh_nxt;    // Shift register
	logic [7:0]  data_nxt;
	logic        vld_nxt;

	////////////////////////////////////////////////////////////////
	// Next state: sample mid-bit, drop frames with a low stop bit
	always_comb begin
		act_nxt  = act_r;
		cnt_nxt  = cnt_r;
		bit_nxt  = bit_r;
		sh_nxt   = sh_r;
		data_nxt = data_r;
		vld_nxt  = 1'b0;
		if (!act_r) begin
			if (!rxd) begin // Start edge
				act_nxt = 1'b1;
				cnt_nxt = bit_cyc >> 1;
				bit_nxt = 4'h0;
			end
		end else if (cnt_r != 17'h00000) begin
			cnt_nxt = cnt_r - 17'h00001;
		end else if (bit_r == 4'h0) begin // Start bit still low?
			act_nxt = !rxd;
			cnt_nxt = bit_cyc - 17'h00001;
			bit_nxt = 4'h1;
		end else if (bit_r <= 4'h8) begin // Data, LSB first
			sh_nxt  = {rxd, sh_r[7:1]};
			cnt_nxt = bit_cyc - 17'h00001;
			bit_nxt = bit_r + 4'h1;
		end else begin // Stop bit
			act_nxt = 1'b0;
			if (rxd) begin
				vld_nxt  = 1'b1;
				data_nxt = sh_r;
			end
		end
	end

	// Registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			act_r  <= 1'b0;
			cnt_r  <= 17'h00000;
			bit_r  <= 4'h0;
			sh_r   <= 8'h00;
			data_r <= 8'h00;
			vld_r  <= 1'b0;
		end else begin
			act_r  <= act_nxt;
			cnt_r  <= cnt_nxt;
			bit_r  <= bit_nxt;
			sh_r   <= sh_nxt;
			data_r <= data_nxt;
			vld_r  <= vld_nxt;
		end
	end
endmodule : serial_rx

// ===== core/serial_tx.sv
// Serial transmitter, one start, eight data, one stop bit
`timescale 1ns/1ps
module serial_tx (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        go,      // Take data when rdy_r
	input  wire logic [7:0]  data,    // Byte to send
	input  wire logic [16:0] bit_cyc, // Clocks per bit
	output logic             line_r,  // Line, idle high
	output logic             rdy_r    // Idle, may take a byte
);
	logic        act_r, act_nxt;   // Frame in progress
	logic [16:0] cnt_r, cnt_nxt;   // Bit timer
	logic [3:0]  bit_r, bit_nxt;   // Bits already sent
	logic [9:0]  sh_r,  sh_nxt;    // Stop, data, start
	logic        line_nxt;

	////////////////////////////////////////////////////////////////
	// Next state: ten bit times per character
	always_comb begin
		act_nxt = act_r;
		cnt_nxt = cnt_r;
		bit_nxt = bit_r;
		sh_nxt  = sh_r;
		if (!act_r) begin
			if (go) begin
				act_nxt = 1'b1;
				sh_nxt  = {1'b1, data, 1'b0};
				cnt_nxt = bit_cyc - 17'h00001;
				bit_nxt = 4'h0;
			end
		end else if (cnt_r != 17'h00000) begin
			cnt_nxt = cnt_r - 17'h00001;
		end else if (bit_r == 4'h9) begin // Stop bit done
			act_nxt = 1'b0;
		end else begin
			sh_nxt  = {1'b1, sh_r[9:1]};
			cnt_nxt = bit_cyc - 17'h00001;
			bit_nxt = bit_r + 4'h1;
		end
		line_nxt = act_nxt ? sh_nxt[0] : 1'b1;
	end

	// Registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			act_r  <= 1'b0;
			cnt_r  <= 17'h00000;
			bit_r  <= 4'h0;
			sh_r   <= 10'h3FF;
			line_r <= 1'b1;
			rdy_r  <= 1'b1;
		end else begin
			act_r  <= act_nxt;
			cnt_r  <= cnt_nxt;
			bit_r  <= bit_nxt;
			sh_r   <= sh_nxt;
			line_r <= line_nxt;
			rdy_r  <= !act_nxt;
		end
	end
endmodule : serial_tx

// ===== core/pump_link_front.sv
// Serial command front end of the pump with its register slave
//
// Behaviour
// [RULE1] Ten-bit frames: start, eight data, stop
// [RULE2] Five selectable link rates, 300 to 19200
// [RULE3] Network address zero to ninety-nine, settable
// [RULE4] Drop commands addressed to other units
// [RULE5] Missing address means address zero
// [RULE6] Ignore traffic while a command is processed
// [RULE7] First response byte ends processing
// [RULE8] Keypad editing postpones command processing
// [RULE9] Every answer carries one status character
// [RULE10] Protocol choice survives power cycles
// [RULE11] Plain mode accepts both formats
// [RULE12] Checked enable answers already in checked
// [RULE13] Command and response characters are ASCII
// [RULE14] Numeric field: four digits, one point (not checked here; the parser stores command bytes without reading numbers)
// [RULE15] Traffic indicator sticky until menu entry
// [RULE16] Downstream port relays traffic for chaining
// [RULE17] Plain mode sends only in reply
// [RULE18] Plain mode strips controls, upper-cases letters
// [RULE19] Checked packets carry sixteen-bit CCITT CRC
// [RULE20] Half-second gap drops partial checked packet (only while chk_r is set; in plain mode a partial checked packet is kept)
// [RULE21] One or two leading digits form address
// [RULE22] Foreign address: send nothing, stay ready
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pump_map.svh"
module pump_link_front #(
	parameter int GAP_CYC = `GAP_CYC // Inter-byte time out in clocks
) (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        rxd,         // From host side
	output logic             txd,         // To host side
	output logic             net_txd,     // To next unit
	input  wire logic        net_rxd,     // From next unit
	input  wire logic        nv_mode_in,  // Stored protocol, 1 checked
	output logic             nv_mode_out, // Protocol to store
	output logic             traffic      // Traffic indicator
);
	////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic is_digit(input logic [7:0] b);
		return (b >= 8'h30) && (b <= 8'h39);
	endfunction : is_digit

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc_step

	// Clocks per bit for a rate selector
	function automatic logic [16:0] bit_cycles(input logic [2:0] sel);
		case (sel)
			3'h0:    return 17'(`BIT_CYC(`BAUD_300));
			3'h1:    return 17'(`BIT_CYC(`BAUD_1200));
			3'h2:    return 17'(`BIT_CYC(`BAUD_2400));
			3'h3:    return 17'(`BIT_CYC(`BAUD_9600));
			default: return 17'(`BIT_CYC(`BAUD_19200));
		endcase
	endfunction : bit_cycles

	////////////////////////////////////////////////////////////////
	// State
	logic [2:0]  baud_r, baud_nxt;        // Rate selector
	logic [6:0]  addr_r, addr_nxt;        // Own network address
	logic        chk_r, chk_nxt;          // Checked protocol in force
	logic        edit_r, edit_nxt;        // Keypad editing
	logic        traf_r, traf_nxt;        // Sticky traffic flag
	pump_pkg::parse_e pst_r, pst_nxt;     // Parser state
	logic [7:0]  buf_r [`BUF_DEPTH];      // Command bytes
	logic [7:0]  buf_nxt [`BUF_DEPTH];
	logic [4:0]  cnt_r, cnt_nxt;          // Bytes stored
	logic [7:0]  raw_r, raw_nxt;          // Checked data left
	logic        pfmt_r, pfmt_nxt;        // Packet is checked format
	logic [15:0] crc_r, crc_nxt;          // Running CRC
	logic [7:0]  rhi_r, rhi_nxt;          // Received CRC high byte
	logic [23:0] gap_r, gap_nxt;          // Inter-byte timer
	logic        pend_r, pend_nxt;        // Command waiting
	logic        busy_r, busy_nxt;        // Deaf until answer starts
	logic        fmt_r, fmt_nxt;          // Format of held command
	logic [1:0]  ofs_r, ofs_nxt;          // Address digits in command
	pump_pkg::resp_e tst_r, tst_nxt;      // Response state
	logic        rchk_r, rchk_nxt;        // Response format
	logic [7:0]  rst_r, rst_nxt;          // Status character
	logic [15:0] tcrc_r, tcrc_nxt;        // Response CRC
	logic [7:0]  tx_byte_r, tx_byte_nxt;  // Byte to sender
	logic        tx_go_r;                 // Sender strobe
	logic        aw_got_r, aw_got_nxt;    // Address latched
	logic        w_got_r, w_got_nxt;      // Data latched
	logic [7:0]  wa_r, wa_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [3:0]  ws_r, ws_nxt;
	logic        bvalid_nxt, rvalid_nxt;
	logic [1:0]  bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	// Wires
	logic [7:0]  rx_data;
	logic        rx_vld, tx_rdy, tx_line;
	logic [16:0] bit_cyc;
	logic        take, finish, fire, wr, resp_go, menu_clr;
	logic [8:0]  pa;

	assign bit_cyc = bit_cycles(baud_r); // see [RULE2]
	assign take    = rx_vld && !busy_r;  // see [RULE6]
	assign fire    = (tst_r != pump_pkg::T_IDLE) && tx_rdy && !tx_go_r;
	assign wr      = aw_got_r && w_got_r && !bvalid;
	assign resp_go = wr && (wa_r == `OFS_RESP) && ws_r[0] && pend_r && !edit_r; // see [RULE8]
	assign menu_clr = wr && (wa_r == `OFS_CTRL) && ws_r[2] && wd_r[`CTRL_MENU_BIT];

	// Leading digits give the address, none gives zero
	always_comb begin
		pa = {2'h0, 7'h00}; // see [RULE5]
		if (cnt_r >= 5'h02 && is_digit(buf_r[0]) && is_digit(buf_r[1])) begin
			pa = {2'h2, 7'(buf_r[0][3:0] * 7'h0A + buf_r[1][3:0])}; // see [RULE21]
		end else if (cnt_r >= 5'h01 && is_digit(buf_r[0])) begin
			pa = {2'h1, 7'(buf_r[0][3:0])}; // see [RULE21]
		end
	end

	serial_rx u_rx (.mclk(mclk), .srst(srst), .rxd(rxd), .bit_cyc(bit_cyc),
		.data_r(rx_data), .vld_r(rx_vld)); // see [RULE1]
	serial_tx u_tx (.mclk(mclk), .srst(srst), .go(tx_go_r), .data(tx_byte_r),
		.bit_cyc(bit_cyc), .line_r(tx_line), .rdy_r(tx_rdy));

	////////////////////////////////////////////////////////////////
	// Packet parser
	always_comb begin
		logic [7:0] b;
		b        = rx_data;
		pst_nxt  = pst_r;
		buf_nxt  = buf_r;
		cnt_nxt  = cnt_r;
		raw_nxt  = raw_r;
		pfmt_nxt = pfmt_r;
		crc_nxt  = crc_r;
		rhi_nxt  = rhi_r;
		finish   = 1'b0;
		gap_nxt  = (pst_r == pump_pkg::P_IDLE) ? 24'h000000 : gap_r + 24'h000001;
		if (take) begin
			gap_nxt = 24'h000000;
			case (pst_r)
				pump_pkg::P_IDLE: begin
					if (b == `CH_STX) begin
						pst_nxt  = pump_pkg::P_LEN;
						cnt_nxt  = 5'h00;
						crc_nxt  = `CRC_INIT;
						pfmt_nxt = 1'b0;
					end
				end
				pump_pkg::P_LEN: begin
					if (b == `CH_ETX) begin // Empty plain packet
						finish  = !chk_r;
						pst_nxt = pump_pkg::P_IDLE;
					end else if (b < `CH_SPACE && b >= `PKT_OVH) begin // see [RULE11]
						pfmt_nxt = 1'b1;
						raw_nxt  = b - `PKT_OVH;
						pst_nxt  = (b == `PKT_OVH) ? pump_pkg::P_CRC1 : pump_pkg::P_DATA;
					end else if (chk_r) begin // Plain packet refused
						pst_nxt = pump_pkg::P_IDLE;
					end else begin
						pst_nxt = pump_pkg::P_DATA;
					end
				end
				pump_pkg::P_DATA: begin
					if (pfmt_r) begin
						crc_nxt = crc_step(crc_r, b); // see [RULE19]
						raw_nxt = raw_r - 8'h01;
						if (raw_r == 8'h01) begin
							pst_nxt = pump_pkg::P_CRC1;
						end
					end else if (b == `CH_ETX) begin
						finish  = 1'b1;
						pst_nxt = pump_pkg::P_IDLE;
					end
				end
				pump_pkg::P_CRC1: begin
					rhi_nxt = b;
					pst_nxt = pump_pkg::P_CRC2;
				end
				pump_pkg::P_CRC2: begin // Corrupt packet dropped
					pst_nxt = ({rhi_r, b} == crc_r) ? pump_pkg::P_ETX : pump_pkg::P_IDLE;
				end
				pump_pkg::P_ETX: begin
					finish  = (b == `CH_ETX);
					pst_nxt = pump_pkg::P_IDLE;
				end
				default: pst_nxt = pump_pkg::P_IDLE;
			endcase
			// Store data bytes, plain ones cleaned first
			if (pst_r == pump_pkg::P_DATA || (pst_r == pump_pkg::P_LEN &&
					pst_nxt == pump_pkg::P_DATA && !pfmt_nxt)) begin
				if (pfmt_r || !(b <= `CH_SPACE || b == `CH_DEL)) begin // see [RULE18]
					if (cnt_r < 5'(`BUF_DEPTH) && !(pst_r == pump_pkg::P_DATA && !pfmt_r
							&& b == `CH_ETX)) begin
						buf_nxt[cnt_r[3:0]] = (!pfmt_r && b >= 8'h61 && b <= 8'h7A) ?
							b - 8'h20 : b;
						cnt_nxt = cnt_r + 5'h01;
					end
				end
			end
		end else if (chk_r && pst_r != pump_pkg::P_IDLE && gap_r >= 24'(GAP_CYC - 1)) begin
			pst_nxt = pump_pkg::P_IDLE; // see [RULE20]
		end
	end

	////////////////////////////////////////////////////////////////
	// Command hand-off and response sequencing
	always_comb begin
		pend_nxt    = pend_r;
		busy_nxt    = busy_r;
		fmt_nxt     = fmt_r;
		ofs_nxt     = ofs_r;
		traf_nxt    = traf_r;
		tst_nxt     = tst_r;
		rchk_nxt    = rchk_r;
		rst_nxt     = rst_r;
		tcrc_nxt    = tcrc_r;
		tx_byte_nxt = tx_byte_r;
		if (menu_clr) begin
			traf_nxt = 1'b0;
		end
		if (finish) begin
			traf_nxt = 1'b1; // see [RULE15]
			if (pa[6:0] == addr_r) begin // see [RULE4] [RULE22]
				pend_nxt = 1'b1;
				busy_nxt = 1'b1;
				fmt_nxt  = pfmt_r;
				ofs_nxt  = pa[8:7];
			end
		end
		if (resp_go) begin // Only a held command may be answered
			pend_nxt = 1'b0; // see [RULE17]
			rst_nxt  = wd_r[7:0]; // see [RULE9]
			rchk_nxt = chk_r; // see [RULE11] [RULE12]
			tcrc_nxt = `CRC_INIT;
			tst_nxt  = pump_pkg::T_STX;
		end
		if (fire) begin
			case (tst_r)
				pump_pkg::T_STX: begin
					tx_byte_nxt = `CH_STX;
					busy_nxt    = 1'b0; // see [RULE7]
					tst_nxt     = rchk_r ? pump_pkg::T_LEN : pump_pkg::T_A1;
				end
				pump_pkg::T_LEN: begin
					tx_byte_nxt = `RESP_LEN;
					tst_nxt     = pump_pkg::T_A1;
				end
				pump_pkg::T_A1: begin // see [RULE13]
					tx_byte_nxt = `CH_ZERO + 8'(addr_r / 7'h0A);
					tst_nxt     = pump_pkg::T_A0;
				end
				pump_pkg::T_A0: begin
					tx_byte_nxt = `CH_ZERO + 8'(addr_r % 7'h0A);
					tst_nxt     = pump_pkg::T_ST;
				end
				pump_pkg::T_ST: begin
					tx_byte_nxt = rst_r;
					tst_nxt     = rchk_r ? pump_pkg::T_C1 : pump_pkg::T_ETX;
				end
				pump_pkg::T_C1: begin
					tx_byte_nxt = tcrc_r[15:8];
					tst_nxt     = pump_pkg::T_C0;
				end
				pump_pkg::T_C0: begin
					tx_byte_nxt = tcrc_r[7:0];
					tst_nxt     = pump_pkg::T_ETX;
				end
				pump_pkg::T_ETX: begin
					tx_byte_nxt = `CH_ETX;
					tst_nxt     = pump_pkg::T_IDLE;
				end
				default: tst_nxt = pump_pkg::T_IDLE;
			endcase
			if (tst_r == pump_pkg::T_A1 || tst_r == pump_pkg::T_A0 || tst_r == pump_pkg::T_ST) begin
				tcrc_nxt = crc_step(tcrc_r, tx_byte_nxt); // see [RULE19]
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Register slave
	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt  = w_got_r;
		wa_nxt     = wa_r;
		wd_nxt     = wd_r;
		ws_nxt     = ws_r;
		bvalid_nxt = bvalid && !bready;
		bresp_nxt  = bresp;
		rvalid_nxt = rvalid && !rready;
		rresp_nxt  = rresp;
		rdata_nxt  = rdata;
		baud_nxt   = baud_r;
		addr_nxt   = addr_r;
		chk_nxt    = chk_r;
		edit_nxt   = edit_r;
		if (awvalid && awready) begin
			aw_got_nxt = 1'b1;
			wa_nxt     = awaddr;
		end
		if (wvalid && wready) begin
			w_got_nxt = 1'b1;
			wd_nxt    = wdata;
			ws_nxt    = wstrb;
		end
		if (wr) begin
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = 2'h0;
			if (wa_r == `OFS_CTRL) begin
				if (ws_r[0]) begin
					baud_nxt = wd_r[`CTRL_BAUD_LSB +: 3];
				end
				if (ws_r[1] && wd_r[`CTRL_ADDR_LSB +: 7] <= `ADDR_MAX) begin
					addr_nxt = wd_r[`CTRL_ADDR_LSB +: 7]; // see [RULE3]
				end
				if (ws_r[2]) begin
					chk_nxt  = wd_r[`CTRL_CHK_BIT]; // see [RULE10]
					edit_nxt = wd_r[`CTRL_EDIT_BIT];
				end
			end else if (wa_r != `OFS_RESP) begin
				bresp_nxt = 2'h2;
			end
		end
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = 2'h0;
			rdata_nxt  = 32'h00000000;
			if (araddr == `OFS_CTRL) begin
				rdata_nxt[`CTRL_BAUD_LSB +: 3] = baud_r;
				rdata_nxt[`CTRL_ADDR_LSB +: 7] = addr_r;
				rdata_nxt[`CTRL_CHK_BIT]       = chk_r;
				rdata_nxt[`CTRL_EDIT_BIT]      = edit_r;
			end else if (araddr == `OFS_STAT) begin
				rdata_nxt = {14'h0000, ofs_r, 3'h0, cnt_r, 3'h0,
					tst_r != pump_pkg::T_IDLE, fmt_r, traf_r, busy_r, pend_r && !edit_r};
			end else if (araddr >= `OFS_CMD0 && araddr <= `OFS_CMD3 && araddr[1:0] == 2'h0) begin
				for (int k = 0; k < 4; k++) begin
					rdata_nxt[8*k +: 8] = buf_r[{araddr[3:2], 2'(k)}];
				end
			end else if (araddr != `OFS_RESP) begin
				rresp_nxt = 2'h2;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			baud_r <= `RST_BAUD;
			addr_r <= `RST_ADDR;
			chk_r  <= nv_mode_in; // see [RULE10]
			edit_r <= 1'b0;
			traf_r <= 1'b0;
			pst_r  <= pump_pkg::P_IDLE;
			for (int k = 0; k < `BUF_DEPTH; k++) begin
				buf_r[k] <= 8'h00;
			end
			cnt_r <= 5'h00; raw_r <= 8'h00; pfmt_r <= 1'b0; crc_r <= `CRC_INIT;
			rhi_r <= 8'h00; gap_r <= 24'h000000; pend_r <= 1'b0; busy_r <= 1'b0;
			fmt_r <= 1'b0; ofs_r <= 2'h0; tst_r <= pump_pkg::T_IDLE; rchk_r <= 1'b0;
			rst_r <= 8'h00; tcrc_r <= `CRC_INIT; tx_byte_r <= 8'h00; tx_go_r <= 1'b0;
			aw_got_r <= 1'b0; w_got_r <= 1'b0; wa_r <= 8'h00; wd_r <= 32'h00000000;
			ws_r <= 4'h0; awready <= 1'b0; wready <= 1'b0; bvalid <= 1'b0;
			bresp <= 2'h0; arready <= 1'b0; rvalid <= 1'b0; rresp <= 2'h0;
			rdata <= 32'h00000000; txd <= 1'b1; net_txd <= 1'b1;
			nv_mode_out <= 1'b0; traffic <= 1'b0;
		end else begin
			baud_r <= baud_nxt; addr_r <= addr_nxt; chk_r <= chk_nxt; edit_r <= edit_nxt;
			traf_r <= traf_nxt; pst_r <= pst_nxt; buf_r <= buf_nxt; cnt_r <= cnt_nxt;
			raw_r <= raw_nxt; pfmt_r <= pfmt_nxt; crc_r <= crc_nxt; rhi_r <= rhi_nxt;
			gap_r <= gap_nxt; pend_r <= pend_nxt; busy_r <= busy_nxt; fmt_r <= fmt_nxt;
			ofs_r <= ofs_nxt; tst_r <= tst_nxt; rchk_r <= rchk_nxt; rst_r <= rst_nxt;
			tcrc_r <= tcrc_nxt; tx_byte_r <= tx_byte_nxt; tx_go_r <= fire;
			aw_got_r <= aw_got_nxt; w_got_r <= w_got_nxt; wa_r <= wa_nxt; wd_r <= wd_nxt;
			ws_r <= ws_nxt; bvalid <= bvalid_nxt; bresp <= bresp_nxt;
			rvalid <= rvalid_nxt; rresp <= rresp_nxt; rdata <= rdata_nxt;
			awready <= !aw_got_nxt && !bvalid_nxt && !(awvalid && awready);
			wready  <= !w_got_nxt && !bvalid_nxt && !(wvalid && wready);
			arready <= !rvalid_nxt && !(arvalid && arready);
			txd     <= tx_line & net_rxd; // see [RULE16]
			net_txd <= rxd;
			nv_mode_out <= chk_nxt;
			traffic <= traf_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	sequence s_start;
		tst_r == pump_pkg::T_IDLE ##1 tst_r == pump_pkg::T_STX;
	endsequence
	sequence s_first_byte;
		fire && tst_r == pump_pkg::T_STX;
	endsequence
	a_busy_deaf: assert property (@(posedge mclk) disable iff (srst) // see [RULE6]
		busy_r |=> cnt_r == $past(cnt_r)) else $error("byte taken while busy");
	a_first_frees: assert property (@(posedge mclk) disable iff (srst) // see [RULE7]
		s_first_byte |=> !busy_r && tx_go_r ##1 !tx_rdy) else $error("busy after answer");
	a_start_prompted: assert property (@(posedge mclk) disable iff (srst) // see [RULE17]
		s_start |-> $past(resp_go)) else $error("unprompted response");
	a_match_holds: assert property (@(posedge mclk) disable iff (srst) // see [RULE4]
		finish && pa[6:0] == addr_r |=> pend_r && busy_r) else $error("match not held");
	a_foreign_quiet: assert property (@(posedge mclk) disable iff (srst) // see [RULE22]
		finish && pa[6:0] != addr_r |=> !busy_r && !pend_r)
		else $error("foreign command answered");
	a_edit_defers: assert property (@(posedge mclk) disable iff (srst) // see [RULE8]
		edit_r && pend_r |=> pend_r) else $error("command taken during edit");
	a_traffic_sticky: assert property (@(posedge mclk) disable iff (srst) // see [RULE15]
		traffic && !menu_clr |=> traffic) else $error("indicator lost");
	a_gap_drop: assert property (@(posedge mclk) disable iff (srst) // see [RULE20]
		chk_r && !take && pst_r != pump_pkg::P_IDLE && gap_r == 24'(GAP_CYC - 1)
		|=> pst_r == pump_pkg::P_IDLE) else $error("partial packet kept");
	a_checked_len: assert property (@(posedge mclk) disable iff (srst) // see [RULE12]
		fire && tst_r == pump_pkg::T_LEN |=> rchk_r && tx_byte_r == `RESP_LEN)
		else $error("bad length byte");
	a_addr_range: assert property (@(posedge mclk) disable iff (srst) // see [RULE3]
		addr_r <= `ADDR_MAX) else $error("address above range");
endmodule : pump_link_front

// ===== dv/host_model.sv
// Host side serial model: sends and receives 8N1 bytes
`timescale 1ns/1ps
`include "pump_map.svh"
module host_model #(
	parameter int BIT_CYC = `BIT_CYC(`BAUD_19200) // Clocks per bit
) (
	input  wire logic mclk,
	input  wire logic txd, // From device
	output logic      rxd  // To device
);
	initial rxd = 1'h1; // Idle high
	////////////////////////////////////////////////////////////////////////////////
	// Start, eight data LSB first, stop
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT_CYC) @(posedge mclk);
		end
	endtask : send
	// Wait for start edge, sample mid-bit
	task automatic recv(output logic [7:0] b);
		int n;
		for (n = 0; n < 40000 && txd; n++) @(posedge mclk);
		repeat (BIT_CYC / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge mclk);
			b[i] = txd;
		end
		repeat (BIT_CYC) @(posedge mclk); // Mid stop bit, so a next call sees a fresh start
	endtask : recv
endmodule : host_model

// ===== dv/tb_serial_pump_command_front_end.sv
// Self-checking bench for the pump serial front end
`timescale 1ns/1ps
`include "pump_map.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_serial_pump_command_front_end;
	logic        mclk = 1'h0, srst = 1'h1;         // Clock and reset
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;  // Addresses
	logic [31:0] wdata = 32'h0, rdata, rd;        // Data
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rs;                // Responses
	logic        rxd, txd, net_txd, nv_mode_out, traffic;
	logic [3:0]  wstrb = 4'hF;                    // Write lanes
	logic        nv_mode_in = 1'h0;               // Stored protocol
	logic [7:0]  b;                               // Received byte
	int          fail_count = 0, checks = 0;
	always #20 mclk = ~mclk; // 25 MHz
	pump_link_front #(.GAP_CYC(2000)) i_pump_link_front (.mclk(mclk), .srst(srst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rxd(rxd),
		.txd(txd), .net_txd(net_txd), .net_rxd(1'h1), .nv_mode_in(nv_mode_in),
		.nv_mode_out(nv_mode_out), .traffic(traffic));
	host_model i_host_model (.mclk(mclk), .txd(txd), .rxd(rxd));
	////////////////////////////////////////////////////////////////////////////////
	// AXI write: address and data together, each released when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'h1;
		w = 1'h1;
		awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1;
		while (aw || w) begin
			@(posedge mclk);
			if (aw && awready) begin aw = 1'h0; awvalid <= 1'h0; end
			if (w && wready) begin w = 1'h0; wvalid <= 1'h0; end
		end
		bready <= 1'h1;
		do @(posedge mclk); while (!bvalid);
		rs = bresp;
		bready <= 1'h0;
	endtask : axw
	// AXI read
	task automatic axr(input logic [7:0] a);
		araddr <= a; arvalid <= 1'h1;
		do @(posedge mclk); while (!arready);
		arvalid <= 1'h0; rready <= 1'h1;
		do @(posedge mclk); while (!rvalid);
		rd = rdata; rs = rresp;
		rready <= 1'h0;
	endtask : axr
	// Verdict
	task automatic summarize();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge mclk);
		srst <= 1'h0;
		@(posedge mclk);
		axr(`OFS_CTRL); `CHK("ctrl reset", 32'h4, rd)
		axr(8'h40); `CHK("unmapped", 2'h2, rs)
		axw(`OFS_CTRL, 32'h6404); axr(`OFS_CTRL); `CHK("addr 100", 32'h4, rd)
		// Address lane masked off: only the rate lane lands
		wstrb <= 4'h1;
		axw(`OFS_CTRL, 32'h0705);
		wstrb <= 4'hF;
		axr(`OFS_CTRL);
		`CHK("lane mask", 32'h5, rd)
		// Lower-case command, no address
		i_host_model.send(`CH_STX); i_host_model.send(8'h78); i_host_model.send(`CH_ETX);
		axr(`OFS_STAT); `CHK("pending", 2'h3, rd[1:0])
		`CHK("digits", 2'h0, rd[17:16])
		`CHK("traffic", 1'h1, traffic)
		axr(`OFS_CMD0); `CHK("upcase", 8'h58, rd[7:0])
		// Keypad editing holds the command back
		axw(`OFS_CTRL, 32'h20004);
		axw(`OFS_RESP, 32'h53);
		axr(`OFS_STAT);
		`CHK("edit hold", 2'h2, rd[1:0])
		// Answer in checked format, then back to plain
		axw(`OFS_CTRL, 32'h10004);
		axw(`OFS_RESP, 32'h53);
		axw(`OFS_CTRL, 32'h4);
		i_host_model.recv(b); `CHK("stx", `CH_STX, b)
		axr(`OFS_STAT); `CHK("busy", 1'h0, rd[1])
		`CHK("answering", 1'h1, rd[4])
		// Next command only after the answer began, addressed elsewhere
		i_host_model.send(`CH_STX); i_host_model.send(8'h35); i_host_model.send(`CH_ETX);
		axr(`OFS_STAT); `CHK("foreign", 1'h0, rd[0])
		axw(`OFS_CTRL, 32'h40004); `CHK("menu", 1'h0, traffic)
		// Power-up protocol comes from storage
		nv_mode_in <= 1'h1;
		srst <= 1'h1;
		repeat (4) @(posedge mclk);
		srst <= 1'h0;
		@(posedge mclk);
		axr(`OFS_CTRL);
		`CHK("stored mode", 32'h10004, rd)
		`CHK("nv mode", 1'h1, nv_mode_out)
		axw(`OFS_CTRL, 32'h4);
		repeat (2) @(posedge mclk);
		`CHK("nv plain", 1'h0, nv_mode_out)
		summarize();
	end
	// Watchdog
	initial begin
		repeat (99000) @(posedge mclk);
		fail_count++;
		summarize();
	end
endmodule : tb_serial_pump_command_front_end
